// *** eb_pkg.sv ***
// Shared constants, carriers and code tables for the 8B/10B codec
package eb_pkg;

   localparam int EB_CHAR_W     = 10;
   localparam int EB_FIFO_DEPTH = 8;
   localparam int EB_DIV_W      = 8;
   localparam int EB_BIT_DIV    = 1;

   localparam logic       EB_RD_INIT   = 1'h0;
   localparam logic [7:0] EB_FORCE_NEG = 8'hE1;
   localparam logic [7:0] EB_FORCE_POS = 8'hE2;
   localparam logic [7:0] EB_COMMA     = 8'hBC;
   localparam logic [4:0] EB_K28_X     = 5'h1C;
   localparam logic [5:0] EB_K28_6B    = 6'h0F;
   localparam logic [5:0] EB_6B_BAL_N  = 6'h38;
   localparam logic [5:0] EB_6B_BAL_P  = 6'h07;
   localparam logic [3:0] EB_4B_BAL_N  = 4'hC;
   localparam logic [3:0] EB_4B_BAL_P  = 4'h3;
   localparam logic [3:0] EB_4B_ALT7   = 4'h7;

   // abcdei for each EDCBA value, negative column, entry 31 first
   localparam logic [31:0][5:0] EB_6B_TABLE = {
      6'h2B, 6'h1E, 6'h2E, 6'h0E, 6'h36, 6'h16, 6'h26, 6'h33,
      6'h3A, 6'h1A, 6'h2A, 6'h0B, 6'h32, 6'h13, 6'h23, 6'h1B,
      6'h17, 6'h1C, 6'h2C, 6'h0D, 6'h34, 6'h15, 6'h25, 6'h39,
      6'h38, 6'h19, 6'h29, 6'h35, 6'h31, 6'h2D, 6'h1D, 6'h27};

   // fghj for each HGF value when the six-bit block ended negative
   localparam logic [7:0][3:0] EB_4B_DATA = {
      4'hE, 4'h6, 4'hA, 4'hD, 4'hC, 4'h5, 4'h9, 4'hB};
   localparam logic [7:0][3:0] EB_4B_SPEC = {
      4'h7, 4'h9, 4'h5, 4'hD, 4'hC, 4'hA, 4'h6, 4'hB};

   typedef struct packed {
      logic       special;
      logic [7:0] value;
   } eb_byte_t;

   typedef struct packed {
      logic       violation;
      logic       special;
      logic [7:0] value;
   } eb_dec_t;

endpackage

// *** eb_codec.sv ***
// Byte FIFO plus 8B/10B transmit encoder, serializer and receive checker
`timescale 1ns/1ps
`default_nettype none

module eb_fifo
   import eb_pkg::*;
#(
   parameter int WIDTH = 9,
   parameter int DEPTH = EB_FIFO_DEPTH
) (
   // Clock and reset
   input  wire logic             core_clk,
   input  wire logic             rst_n,
   // Fill side
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   // Drain side
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic [WIDTH-1:0]      out_data
);

   localparam int AW = $clog2(DEPTH);

   generate
      if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin : g_chk
         $error("eb_fifo: DEPTH must be a power of two, at least 2");
      end
   endgenerate

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [AW-1:0]               wptr;
      logic [AW-1:0]               rptr;
      logic [AW:0]                 count;
      logic                        in_ready;
      logic                        out_valid;
   } fifo_st_t;

   fifo_st_t st;
   fifo_st_t next_st;
   logic     push;
   logic     pop;

   always_comb begin
      next_st = st;
      push    = in_valid & st.in_ready;
      pop     = out_ready & st.out_valid;
      if (push) begin
         next_st.mem[st.wptr] = in_data;
         next_st.wptr         = st.wptr + 1'b1;
      end
      if (pop) begin
         next_st.rptr = st.rptr + 1'b1;
      end
      if (push && !pop) begin
         next_st.count = st.count + 1'b1;
      end else if (pop && !push) begin
         next_st.count = st.count - 1'b1;
      end
      // Flags kept as flops so ready never depends on the drain side
      next_st.in_ready  = next_st.count != (AW + 1)'(DEPTH);
      next_st.out_valid = next_st.count != '0;
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         st          <= '0;
         st.in_ready <= 1'b1;
      end else begin
         st <= next_st;
      end
   end

   assign in_ready  = st.in_ready;
   assign out_valid = st.out_valid;
   assign out_data  = st.mem[st.rptr];

endmodule

module eb_codec
   import eb_pkg::*;
#(
   parameter int BIT_DIV = EB_BIT_DIV,
   parameter int DEPTH   = EB_FIFO_DEPTH
) (
   // Clock and reset
   input  wire logic             core_clk,
   input  wire logic             rst_n,
   // Byte intake
   input  wire logic             tx_valid,
   output logic                  tx_ready,
   input  wire eb_byte_t         tx_byte,
   // Serial and parallel transmit view
   output logic                  ser_bit,
   output logic                  ser_start,
   output logic [EB_CHAR_W-1:0]  tx_char,
   output logic                  tx_rd,
   // Received characters
   input  wire logic             rx_valid,
   input  wire logic [EB_CHAR_W-1:0] rx_char,
   // Decoded result
   output logic                  rx_out_valid,
   output eb_dec_t               rx_out,
   output logic                  rx_rd
);

   generate
      if (BIT_DIV < 1 || BIT_DIV >= (1 << EB_DIV_W)) begin : g_chk
         $error("eb_codec: BIT_DIV out of range");
      end
   endgenerate

   localparam logic [3:0] LAST_BIT = 4'(EB_CHAR_W - 1);
   localparam logic [EB_DIV_W-1:0] DIV_LAST = EB_DIV_W'(BIT_DIV - 1);

   // Sub-block end disparity, six or four bits
   function automatic logic blk_rd(input logic [5:0] bits,
                                   input logic       six,
                                   input logic       rd_in);
      int ones;
      int half;
      ones = 0;
      for (int i = 0; i < 6; i++) begin
         if (six || i < 4) begin
            ones = ones + int'(bits[i]);
         end
      end
      half = six ? 3 : 2;
      if (ones > half) begin
         blk_rd = 1'b1;
      end else if (ones < half) begin
         blk_rd = 1'b0;
      end else if (six && bits == EB_6B_BAL_P) begin
         blk_rd = 1'b1;
      end else if (six && bits == EB_6B_BAL_N) begin
         blk_rd = 1'b0;
      end else if (!six && bits[3:0] == EB_4B_BAL_P) begin
         blk_rd = 1'b1;
      end else if (!six && bits[3:0] == EB_4B_BAL_N) begin
         blk_rd = 1'b0;
      end else begin
         blk_rd = rd_in;
      end
   endfunction

   // Disparity after a whole character
   function automatic logic char_rd(input logic [9:0] c,
                                    input logic       rd_in);
      logic mid;
      mid     = blk_rd(c[9:4], 1'b1, rd_in);
      char_rd = blk_rd({2'h0, c[3:0]}, 1'b0, mid);
   endfunction

   function automatic logic is_special(input logic [7:0] v);
      is_special = (v[4:0] == EB_K28_X) ||
                   (v == 8'hF7) || (v == 8'hFB) ||
                   (v == 8'hFD) || (v == 8'hFE);
   endfunction

   // Returns {end disparity, abcdei, fghj}
   function automatic logic [10:0] encode(input eb_byte_t b,
                                          input logic     rd_in);
      logic [4:0] x;
      logic [2:0] y;
      logic [5:0] s6;
      logic [3:0] f4;
      logic       rd;
      logic       mid;
      logic       kc;
      logic       alt;
      logic [9:0] c;
      rd = rd_in;
      kc = b.special;
      if (kc && b.value == EB_FORCE_NEG) begin
         b.value = EB_COMMA;
         rd      = 1'b0;
      end else if (kc && b.value == EB_FORCE_POS) begin
         b.value = EB_COMMA;
         rd      = 1'b1;
      end else if (kc && !is_special(b.value)) begin
         b.value = EB_COMMA;
      end
      x  = b.value[4:0];
      y  = b.value[7:5];
      s6 = (kc && x == EB_K28_X) ? EB_K28_6B : EB_6B_TABLE[x];
      if (rd && ($countones(s6) != 3 || s6 == EB_6B_BAL_N)) begin
         s6 = ~s6;
      end
      mid = blk_rd(s6, 1'b1, rd);
      alt = (!mid && (x == 5'h11 || x == 5'h12 || x == 5'h14)) ||
            (mid && (x == 5'h0B || x == 5'h0D || x == 5'h0E));
      if (kc) begin
         f4 = EB_4B_SPEC[y];
         if (mid) begin
            f4 = ~f4;
         end
      end else begin
         f4 = (y == 3'h7 && alt) ? EB_4B_ALT7 : EB_4B_DATA[y];
         if (mid && ($countones(f4) != 2 || f4 == EB_4B_BAL_N)) begin
            f4 = ~f4;
         end
      end
      c      = {s6, f4};
      encode = {char_rd(c, rd), c};
   endfunction

   // Searches the column of the given disparity only.
   // Exhaustive search through the encoder keeps one source of truth
   // for both directions; it costs area, a dedicated table would not.
   // A forcing code is never reported: it aliases the comma entry.
   function automatic eb_dec_t decode(input logic [9:0] c,
                                      input logic       rd);
      eb_dec_t    d;
      eb_byte_t   b;
      logic [10:0] e;
      d = '{violation: 1'b1, special: 1'b0, value: 8'h00};
      for (int k = 0; k < 2; k++) begin
         for (int i = 0; i < 256; i++) begin
            b.special = k[0];
            b.value   = 8'(i);
            e = encode(b, rd);
            if (d.violation && e[9:0] == c &&
                (!b.special || is_special(b.value))) begin
               d.violation = 1'b0;
               d.special   = b.special;
               d.value     = b.value;
            end
         end
      end
      decode = d;
   endfunction

   typedef struct packed {
      logic [EB_DIV_W-1:0]  div;
      logic                 bit_en;
      logic                 busy;
      logic [3:0]           cnt;
      logic [EB_CHAR_W-1:0] shreg;
      logic                 ser_bit;
      logic                 ser_start;
      logic [EB_CHAR_W-1:0] tx_char;
      logic                 tx_rd;
      logic                 rx_rd;
      logic                 rx_out_valid;
      eb_dec_t              rx_out;
   } eb_st_t;

   eb_st_t      st;
   eb_st_t      next_st;
   logic        f_valid;
   logic        f_ready;
   eb_byte_t    f_data;
   logic [10:0] enc;

   eb_fifo #(
      .WIDTH ($bits(eb_byte_t)),
      .DEPTH (DEPTH)
   ) u_fifo (
      .core_clk  (core_clk),
      .rst_n     (rst_n),
      .in_valid  (tx_valid),
      .in_ready  (tx_ready),
      .in_data   (tx_byte),
      .out_valid (f_valid),
      .out_ready (f_ready),
      .out_data  (f_data)
   );

   // Drain only at a character boundary, so a slow line fills the FIFO.
   // The pop and the launch of bit a share one bit enable.
   assign f_ready = st.bit_en & (~st.busy | (st.cnt == LAST_BIT));

   always_comb begin
      next_st              = st;
      next_st.ser_start    = 1'b0;
      next_st.rx_out_valid = 1'b0;
      enc                  = encode(f_data, st.tx_rd);
      next_st.bit_en       = st.div == DIV_LAST;
      next_st.div          = (st.div == DIV_LAST) ? '0 : st.div + 1'b1;
      if (st.bit_en) begin
         if (st.busy && st.cnt != LAST_BIT) begin
            next_st.shreg   = {st.shreg[8:0], 1'b0};
            next_st.ser_bit = st.shreg[8];
            next_st.cnt     = st.cnt + 1'b1;
         end else if (f_valid) begin
            next_st.shreg     = enc[9:0];
            next_st.ser_bit   = enc[9];
            next_st.cnt       = '0;
            next_st.busy      = 1'b1;
            next_st.ser_start = 1'b1;
            next_st.tx_char   = enc[9:0];
            next_st.tx_rd     = enc[10];
         end else begin
            // Line holds its last bit while nothing is queued
            next_st.busy = 1'b0;
         end
      end
      // Receive path has no back pressure; a result per character
      if (rx_valid) begin
         next_st.rx_out       = decode(rx_char, st.rx_rd);
         next_st.rx_out_valid = 1'b1;
         next_st.rx_rd        = char_rd(rx_char, st.rx_rd);
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         st       <= '0;
         st.tx_rd <= EB_RD_INIT;
         st.rx_rd <= EB_RD_INIT;
      end else begin
         st <= next_st;
      end
   end

   assign ser_bit      = st.ser_bit;
   assign ser_start    = st.ser_start;
   assign tx_char      = st.tx_char;
   assign tx_rd        = st.tx_rd;
   assign rx_out_valid = st.rx_out_valid;
   assign rx_out       = st.rx_out;
   assign rx_rd        = st.rx_rd;

endmodule

`default_nettype wire

// *** eb_codec_monitor.sv ***
// Concurrent checks on the codec's serial and receive ports
`timescale 1ns/1ps
`default_nettype none
module eb_codec_monitor
   import eb_pkg::*;
#(
   parameter int BIT_DIV = 1
) (
   // Clock and reset
   input wire logic                 core_clk,
   input wire logic                 rst_n,
   // Transmit view
   input wire logic                 ser_bit,
   input wire logic                 ser_start,
   input wire logic [EB_CHAR_W-1:0] tx_char,
   input wire logic                 tx_rd,
   // Receive view
   input wire logic                 rx_valid,
   input wire logic [EB_CHAR_W-1:0] rx_char,
   input wire logic                 rx_out_valid,
   input wire eb_dec_t              rx_out,
   input wire logic                 rx_rd
);
   // Bit slots assume one clock per bit
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_n);

   function automatic logic nrd(logic [9:0] c, logic r);
      logic s;
      s = ($countones(c[9:4]) > 3 || c[9:4] == 6'h07) ? 1'b1 :
          ($countones(c[9:4]) < 3 || c[9:4] == 6'h38) ? 1'b0 : r;
      return ($countones(c[3:0]) > 2 || c[3:0] == 4'h3) ? 1'b1 :
             ($countones(c[3:0]) < 2 || c[3:0] == 4'hC) ? 1'b0 : s;
   endfunction

   sequence s_launch;
      ser_start;
   endsequence

   a_first_bit: assert property (s_launch |-> ser_bit == tx_char[9])
      else $error("First serial bit is not a");
   a_bit_i_slot: assert property (s_launch |-> ##5 ser_bit == tx_char[4])
      else $error("Sixth serial bit is not i");
   a_last_bit: assert property (s_launch |-> ##9 ser_bit == tx_char[0])
      else $error("Tenth serial bit is not j");
   a_char_spacing: assert property (s_launch |=> (!ser_start)[*8])
      else $error("Characters overlap on the line");
   a_tx_rd_rule: assert property (s_launch |-> tx_rd == nrd(tx_char, $past(tx_rd)))
      else $error("Transmit disparity not from sent bits");
   a_rx_answer: assert property (rx_valid |=> rx_out_valid)
      else $error("No result after a received character");
   a_rx_quiet: assert property (!rx_valid |=> !rx_out_valid)
      else $error("Result without a received character");
   a_rx_rd_rule: assert property (rx_valid |=> rx_rd == nrd($past(rx_char), $past(rx_rd)))
      else $error("Receive disparity not from received bits");
   a_viol_clean: assert property (rx_out_valid && rx_out.violation |-> rx_out[8:0] == 9'h000)
      else $error("Violation result carries a value");
endmodule
`default_nettype wire

// *** eb_link_model.sv ***
// Far-end line receiver: collects ten serial bits into a character
`timescale 1ns/1ps
`default_nettype none
module eb_link_model
   import eb_pkg::*;
(
   // Clock and reset
   input wire logic                 core_clk,
   input wire logic                 rst_n,
   // Serial line
   input wire logic                 ser_bit,
   input wire logic                 ser_start,
   // Recovered characters
   output logic                     rx_valid,
   output logic [EB_CHAR_W-1:0]     rx_char
);
   logic [3:0] cnt;
   logic [8:0] sh;

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt <= 4'h0;
         sh <= 9'h000;
         rx_valid <= 1'b0;
         rx_char <= 10'h000;
      end else begin
         rx_valid <= 1'b0;
         // Idle character lines toggle so stale data never looks valid
         rx_char <= ~rx_char;
         if (ser_start) begin
            sh <= {8'h00, ser_bit};
            cnt <= 4'h1;
         end else if (cnt != 4'h0) begin
            sh <= {sh[7:0], ser_bit};
            cnt <= (cnt == 4'h9) ? 4'h0 : cnt + 4'h1;
            if (cnt == 4'h9) begin
               rx_valid <= 1'b1;
               rx_char <= {sh, ser_bit};
            end
         end
      end
   end
endmodule
`default_nettype wire

// *** eb_codec_tb_top.sv ***
// Loopback testbench for the codec with a reference disparity model
`timescale 1ns/1ps
`default_nettype none
module eb_codec_tb_top
   import eb_pkg::*;
;
   logic core_clk = 1'b0;
   logic rst_n, tx_valid, tx_ready, ser_bit, ser_start, tx_rd;
   logic rx_out_valid, rx_rd, lk_rv, tb_rv, rx_valid, mrd, rrd;
   logic [9:0] tx_char, lk_rc, tb_rc, rx_char;
   eb_byte_t tx_byte, b;
   eb_dec_t rx_out;
   int err_total, num_checks, i;
   eb_byte_t txq[$];
   eb_dec_t rxq[$];
   logic [9:0] rcq[$];
   logic [7:0] kl[16] = '{8'h1C, 8'h3C, 8'h5C, 8'h7C, 8'h9C, 8'hBC, 8'hDC,
      8'hFC, 8'hF7, 8'hFB, 8'hFD, 8'hFE, 8'hE1, 8'hE1, 8'hE2, 8'hE2};
   logic [9:0] ic[4] = '{10'h3FF, 10'h000, 10'h18B, 10'h295};
   logic [9:0] ie[4] = '{10'h200, 10'h200, 10'h200, 10'h045};

   always #2.5 core_clk = ~core_clk;
   assign rx_valid = lk_rv | tb_rv;
   assign rx_char = tb_rv ? tb_rc : lk_rc;

   eb_codec dut (.core_clk(core_clk), .rst_n(rst_n), .tx_valid(tx_valid),
      .tx_ready(tx_ready), .tx_byte(tx_byte), .ser_bit(ser_bit),
      .ser_start(ser_start), .tx_char(tx_char), .tx_rd(tx_rd),
      .rx_valid(rx_valid), .rx_char(rx_char), .rx_out_valid(rx_out_valid),
      .rx_out(rx_out), .rx_rd(rx_rd));
   eb_link_model link (.core_clk(core_clk), .rst_n(rst_n), .ser_bit(ser_bit),
      .ser_start(ser_start), .rx_valid(lk_rv), .rx_char(lk_rc));

   function automatic logic nrd(logic [9:0] c, logic r);
      logic s;
      s = ($countones(c[9:4]) > 3 || c[9:4] == 6'h07) ? 1'b1 :
          ($countones(c[9:4]) < 3 || c[9:4] == 6'h38) ? 1'b0 : r;
      return ($countones(c[3:0]) > 2 || c[3:0] == 4'h3) ? 1'b1 :
             ($countones(c[3:0]) < 2 || c[3:0] == 4'hC) ? 1'b0 : s;
   endfunction

   task automatic chk(logic [9:0] seen, logic [9:0] exp);
      num_checks++;
      if (seen !== exp) begin
         err_total++;
         $display("Error at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic tally_and_finish();
      $display("Checks %0d, errors %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask

   // Called at a clock edge; returns at the edge that took the byte
   task automatic send(eb_byte_t v);
      int n;
      tx_valid <= 1'b1;
      tx_byte <= v;
      n = 0;
      do begin
         @(posedge core_clk);
         n++;
      end while (!tx_ready && n < 400);
      if (n >= 400) begin
         err_total++;
         tally_and_finish();
      end
      txq.push_back(v);
   endtask

   task automatic drain();
      int n;
      for (n = 0; n < 3000 && (txq.size() + rxq.size()) > 0; n++)
         @(posedge core_clk);
      if (n >= 3000) begin
         err_total++;
         tally_and_finish();
      end
   endtask

   // Reference disparity model and receiver, checked at every result
   always @(negedge core_clk) begin
      if (rst_n && ser_start) begin
         b = txq.pop_front();
         if (b.special && b.value == 8'hE1) chk(tx_char, 10'h0FA);
         else if (b.special && b.value == 8'hE2) chk(tx_char, 10'h305);
         else chk(mrd ? ($countones(tx_char[9:4]) <= 3) : ($countones(tx_char[9:4]) >= 3), 1);
         // Forced column only decodes when the far side sits at that polarity
         if (b.special && (b.value == 8'hE1 || b.value == 8'hE2))
            rxq.push_back((mrd == b.value[1]) ? 10'h1BC : 10'h200);
         else rxq.push_back({1'b0, b});
         mrd = nrd(tx_char, mrd);
         chk(tx_rd, mrd);
         rcq.push_back(tx_char);
      end
      if (rst_n && rx_out_valid) begin
         chk(rx_out, rxq.pop_front());
         rrd = nrd(rcq.pop_front(), rrd);
         chk(rx_rd, rrd);
      end
   end

   initial begin
      rst_n = 1'b0;
      tx_valid = 1'b0;
      tx_byte = '0;
      tb_rv = 1'b0;
      tb_rc = 10'h000;
      err_total = 0;
      num_checks = 0;
      mrd = EB_RD_INIT;
      rrd = EB_RD_INIT;
      void'($urandom(32'h427855be));
      repeat (12) @(posedge core_clk);
      chk(tx_ready, 1);
      chk(tx_rd, EB_RD_INIT);
      chk(rx_rd, EB_RD_INIT);
      rst_n <= 1'b1;
      @(posedge core_clk);
      send(9'h045);
      tx_valid <= 1'b0;
      drain();
      chk(tx_char, 10'h295);
      // Burst outruns the line, so the FIFO fills and refuses
      for (i = 0; i < 30; i++) send({1'b0, 8'($urandom)});
      for (i = 0; i < 16; i++) send({1'b1, kl[i]});
      tx_valid <= 1'b0;
      drain();
      tb_rv <= 1'b1;
      for (i = 0; i < 4; i++) begin
         tb_rc <= ic[i];
         rxq.push_back(ie[i]);
         rcq.push_back(ic[i]);
         @(posedge core_clk);
      end
      tb_rv <= 1'b0;
      drain();
      tally_and_finish();
   end
endmodule

bind eb_codec eb_codec_monitor #(.BIT_DIV(BIT_DIV)) u_mon (.core_clk(core_clk),
   .rst_n(rst_n), .ser_bit(ser_bit), .ser_start(ser_start),
   .tx_char(tx_char), .tx_rd(tx_rd), .rx_valid(rx_valid), .rx_char(rx_char),
   .rx_out_valid(rx_out_valid), .rx_out(rx_out), .rx_rd(rx_rd));
`default_nettype wire
